/* File: ebtc_timer.sv */
`timescale 1ns/1ps
`include "ebtc_consts.svh"

// Notes on behaviour
// - The count is one 8-bit register that software reads and writes.
// - The counter owns a private 8-bit prescaler, shared with nothing else.
// - Timer mode without prescaler adds one each instruction cycle.
// - Source select cleared means timer mode on the instruction clock.
// - Counting is held off for two instruction cycles after a count write.
// - Counter mode adds one on one chosen edge of the count pin.
// - Edge select one counts falling edges, zero counts rising edges.
// - Source select set means counter mode on the count pin.
// - An overflow indication is offered as a gate source for another timer.
// - Wrap from all ones sets the overflow flag always; software clears it.
// - Bypass cleared engages prescaler; rate picks 1:2 to 1:256; bypass gives 1:1.
// - Any count write clears the prescaler; the prescaler is not software visible.
// - During sleep nothing counts and the count stays unchanged.
module ebtc_timer
  import ebtc_pkg::*;
#(
  parameter int INSN_DIV = `EBTC_INSN_DIV
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic i_sleep,
  input wire logic i_count_pin,
  output logic o_overflow_gate,
  output logic o_irq
);
  localparam int DIV_W = (INSN_DIV > 1) ? $clog2(INSN_DIV) : 1;

  initial begin
    if (INSN_DIV < 1) begin
      $error("ebtc_timer: INSN_DIV must be at least 1");
    end
  end

  function automatic logic ebtc_hit(input logic [7:0] addr, input logic [7:0] off);
    ebtc_hit = (addr == off);
  endfunction

  // Bus state
  logic dph_wr;
  logic [7:0] dph_addr;
  logic addr_ok;
  logic rd_take;
  logic wr_take;
  logic cnt_wr;
  logic ctrl_wr;
  logic stat_wr;
  logic mask_wr;
  logic stat_rd;

  // Block state
  logic [`EBTC_CNT_W-1:0] count_register;
  logic [5:0] ctrl;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic [DIV_W-1:0] insn_cnt;
  logic insn_en;
  logic [1:0] inhibit;
  logic pin_s1;
  logic pin_s2;
  logic pin_s3;
  logic pin_lvl;
  logic pin_ev;
  logic presc_src;
  logic presc_tick;
  logic tick_d1;
  logic tick_d2;
  logic inc;
  logic ovf_ev;

  ebtc_src_t clock_source_select;
  logic source_edge_select;
  logic prescaler_bypass;
  ebtc_rate_t prescale_rate;

  assign clock_source_select = ebtc_src_t'(ctrl[`EBTC_CTRL_SRC]);
  assign source_edge_select = ctrl[`EBTC_CTRL_EDGE];
  assign prescaler_bypass = ctrl[`EBTC_CTRL_BYP];
  assign prescale_rate = ctrl[`EBTC_CTRL_RATE_HI:`EBTC_CTRL_RATE_LO];

  // Address phase: only NONSEQ/SEQ with hready count
  assign addr_ok = i_hsel && i_htrans[1] && i_hready;
  assign rd_take = addr_ok && !i_hwrite;
  assign wr_take = addr_ok && i_hwrite;
  assign stat_rd = rd_take && ebtc_hit(i_haddr[7:0], `EBTC_OFF_STAT);
  assign cnt_wr = dph_wr && ebtc_hit(dph_addr, `EBTC_OFF_COUNT);
  assign ctrl_wr = dph_wr && ebtc_hit(dph_addr, `EBTC_OFF_CTRL);
  assign stat_wr = dph_wr && ebtc_hit(dph_addr, `EBTC_OFF_STAT);
  assign mask_wr = dph_wr && ebtc_hit(dph_addr, `EBTC_OFF_MASK);

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      dph_wr <= 1'b0;
      dph_addr <= 8'h00;
    end else begin
      dph_wr <= wr_take;
      dph_addr <= i_haddr[7:0];
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_hreadyout <= 1'b0;
      o_hresp <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
  end

  // Read data registered at the end of the address phase; unmapped reads zero
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      o_hrdata <= 32'h0000_0000;
      if (ebtc_hit(i_haddr[7:0], `EBTC_OFF_COUNT)) begin
        o_hrdata <= {24'h00_0000, count_register};
      end else if (ebtc_hit(i_haddr[7:0], `EBTC_OFF_CTRL)) begin
        o_hrdata <= {26'h000_0000, ctrl};
      end else if (stat_rd) begin
        o_hrdata[`EBTC_STAT_OVF] <= overflow_flag;
      end else if (ebtc_hit(i_haddr[7:0], `EBTC_OFF_MASK)) begin
        o_hrdata[`EBTC_STAT_OVF] <= overflow_irq_enable;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ctrl <= `EBTC_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl <= i_hwdata[5:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      overflow_irq_enable <= 1'b0;
    end else if (mask_wr) begin
      overflow_irq_enable <= i_hwdata[`EBTC_STAT_OVF];
    end
  end

  // Instruction-cycle enable; the core clock runs INSN_DIV times faster
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      insn_cnt <= '0;
      insn_en <= 1'b0;
    end else if (insn_cnt == DIV_W'(INSN_DIV - 1)) begin
      insn_cnt <= '0;
      insn_en <= 1'b1;
    end else begin
      insn_cnt <= insn_cnt + 1'b1;
      insn_en <= 1'b0;
    end
  end

  // Pin resync: a change counts once the second and third stages agree
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
    end else begin
      pin_s1 <= i_count_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      pin_lvl <= 1'b0;
      pin_ev <= 1'b0;
    end else begin
      pin_ev <= 1'b0;
      if ((pin_s2 == pin_s3) && (pin_s3 != pin_lvl)) begin
        pin_lvl <= pin_s3;
        pin_ev <= (pin_s3 != source_edge_select);
      end
    end
  end

  // Sleep freezes the prescaler too, so no partial period leaks through
  always_comb begin
    presc_src = 1'b0;
    if (!i_sleep) begin
      presc_src = (clock_source_select == EBTC_SRC_PIN) ? pin_ev : insn_en;
    end
  end

  ebtc_prescaler #(
    .WIDTH(`EBTC_PRESC_W)
  ) u_presc (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_clear(cnt_wr),
    .i_src(presc_src),
    .i_bypass(prescaler_bypass),
    .i_rate(prescale_rate),
    .o_tick(presc_tick)
  );

  // Two-stage resync of the prescaled pin edge; costs two core cycles of latency
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      tick_d1 <= 1'b0;
      tick_d2 <= 1'b0;
    end else begin
      tick_d1 <= presc_tick && (clock_source_select == EBTC_SRC_PIN);
      tick_d2 <= tick_d1;
    end
  end

  // Hold-off after a count write, measured in instruction cycles
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      inhibit <= 2'h0;
    end else if (cnt_wr) begin
      inhibit <= `EBTC_INHIBIT;
    end else if (insn_en && (inhibit != 2'h0)) begin
      inhibit <= inhibit - 2'h1;
    end
  end

  always_comb begin
    inc = 1'b0;
    if (!i_sleep && (inhibit == 2'h0)) begin
      if (clock_source_select == EBTC_SRC_PIN) begin
        inc = tick_d2;
      end else begin
        inc = presc_tick;
      end
    end
  end

  // A count write in the same cycle drops the increment, so it must not flag a wrap either
  assign ovf_ev = inc && !cnt_wr && (count_register == `EBTC_COUNT_MAX);

  // A software write beats a same-cycle increment
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      count_register <= `EBTC_COUNT_RST;
    end else if (cnt_wr) begin
      count_register <= i_hwdata[`EBTC_CNT_W-1:0];
    end else if (inc) begin
      count_register <= count_register + 1'b1;
    end
  end

  // Set wins over clear; cleared by a status read or by writing one
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      overflow_flag <= 1'b0;
    end else if (ovf_ev) begin
      overflow_flag <= 1'b1;
    end else if (stat_rd || (stat_wr && i_hwdata[`EBTC_STAT_OVF])) begin
      overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_overflow_gate <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      o_overflow_gate <= ovf_ev;
      o_irq <= overflow_flag && overflow_irq_enable;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence s_pin_edge;
    pin_ev && (clock_source_select == EBTC_SRC_PIN) && prescaler_bypass && !i_sleep;
  endsequence

  sequence s_resync;
    tick_d1 ##1 tick_d2;
  endsequence

  property p_count_write;
    cnt_wr |=> (count_register == $past(i_hwdata[7:0]));
  endproperty
  a_count_write: assert property (p_count_write) else $error("count write lost");

  property p_inhibit_load;
    cnt_wr |=> (inhibit == 2'h2) && (u_presc.cnt == 8'h00);
  endproperty
  a_inhibit_load: assert property (p_inhibit_load) else $error("no hold-off");

  property p_inhibit_hold;
    (inhibit != 2'h0) && !cnt_wr |=> $stable(count_register);
  endproperty
  a_inhibit_hold: assert property (p_inhibit_hold) else $error("counted in hold-off");

  property p_timer_inc;
    (clock_source_select == EBTC_SRC_INSN) && prescaler_bypass && insn_en && !i_sleep
      && (inhibit == 2'h0) && !cnt_wr |=> (count_register == $past(count_register) + 8'h01);
  endproperty
  a_timer_inc: assert property (p_timer_inc) else $error("timer missed a cycle");

  property p_sleep;
    i_sleep && !cnt_wr && !tick_d2 |=> $stable(count_register);
  endproperty
  a_sleep: assert property (p_sleep) else $error("counted in sleep");

  property p_pin_path;
    s_pin_edge |=> s_resync;
  endproperty
  a_pin_path: assert property (p_pin_path) else $error("pin edge not resynced");

  property p_overflow;
    ovf_ev |=> overflow_flag && (count_register == 8'h00) && o_overflow_gate ##1 !o_overflow_gate;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged");

  property p_flag_keep;
    overflow_flag && !stat_rd && !stat_wr |=> overflow_flag;
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flag cleared by itself");

  property p_no_pin_in_timer;
    (clock_source_select == EBTC_SRC_INSN) |=> !tick_d1;
  endproperty
  a_no_pin_in_timer: assert property (p_no_pin_in_timer) else $error("pin used in timer mode");

  property p_irq;
    overflow_flag && overflow_irq_enable |=> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule

/* File: ebtc_consts.svh */
`ifndef EBTC_CONSTS_SVH
`define EBTC_CONSTS_SVH

// Register byte offsets on the bus
`define EBTC_OFF_COUNT 8'h00
`define EBTC_OFF_CTRL 8'h04
`define EBTC_OFF_STAT 8'h08
`define EBTC_OFF_MASK 8'h0C

// Control register fields
`define EBTC_CTRL_SRC 5
`define EBTC_CTRL_EDGE 4
`define EBTC_CTRL_BYP 3
`define EBTC_CTRL_RATE_HI 2
`define EBTC_CTRL_RATE_LO 0
`define EBTC_CTRL_RST 6'h3F

// Status and mask field
`define EBTC_STAT_OVF 0

// Widths and counts
`define EBTC_CNT_W 8
`define EBTC_PRESC_W 8
`define EBTC_INSN_DIV 4
`define EBTC_INHIBIT 2'h2
`define EBTC_COUNT_MAX 8'hFF
`define EBTC_COUNT_RST 8'h00

`endif

/* File: ebtc_pkg.sv */
package ebtc_pkg;
  typedef enum logic {
    EBTC_SRC_INSN = 1'b0,
    EBTC_SRC_PIN = 1'b1
  } ebtc_src_t;
  typedef logic [2:0] ebtc_rate_t;
endpackage

/* File: ebtc_prescaler.sv */
`timescale 1ns/1ps
`include "ebtc_consts.svh"

module ebtc_prescaler
  import ebtc_pkg::*;
#(
  parameter int WIDTH = `EBTC_PRESC_W
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_clear,
  input wire logic i_src,
  input wire logic i_bypass,
  input wire ebtc_rate_t i_rate,
  output logic o_tick
);
  logic [WIDTH-1:0] cnt;
  logic [WIDTH-1:0] mask;

  initial begin
    if (WIDTH < 8) begin
      $error("ebtc_prescaler: WIDTH must be at least 8");
    end
  end

  // Rate n divides by 2^(n+1)
  always_comb begin
    mask = '0;
    mask = WIDTH'((16'h0002 << i_rate) - 16'h0001);
  end

  // Internal count is invisible to software; only a count write or reset clears it
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cnt <= '0;
    end else if (i_clear) begin
      cnt <= '0;
    end else if (i_src && !i_bypass) begin
      cnt <= cnt + 1'b1;
    end
  end

  // One tick per full period; bypass passes every source event
  always_comb begin
    o_tick = i_bypass ? i_src : (i_src && ((cnt & mask) == mask));
  end
endmodule

/* File: ebtc_pin_model.sv */
`timescale 1ns/1ps
module ebtc_pin_model #(
  parameter int HALF = 6
) (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [3:0] i_toggles,
  output logic o_pin,
  output logic o_busy
);
  int left = 0;
  int tmr = 0;
  logic lvl = 1'b0;
  // Each level lasts HALF+1 core cycles, longer than the resync needs
  always @(posedge i_clk) begin
    if (i_go) begin
      left <= int'(i_toggles);
      tmr <= HALF;
    end else if (left != 0 && tmr == 0) begin
      lvl <= ~lvl;
      left <= left - 1;
      tmr <= HALF;
    end else if (tmr != 0) begin
      tmr <= tmr - 1;
    end
  end
  assign o_busy = (left != 0);
  assign o_pin = lvl;
endmodule

/* File: ebtc_timer_bench.sv */
`timescale 1ns/1ps
module ebtc_timer_bench;
  import ebtc_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] wd; logic [31:0] rb; logic [31:0] ra;} ebtc_row_t;
  typedef struct packed {logic [7:0] ctl; logic [3:0] n; logic [7:0] e;} ebtc_pin_row_t;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_hsel = 1'b0;
  logic [31:0] i_haddr = 32'h0;
  logic [1:0] i_htrans = 2'h0;
  logic i_hwrite = 1'b0;
  logic [31:0] i_hwdata = 32'h0;
  logic i_sleep = 1'b0;
  logic go = 1'b0;
  logic [3:0] tog = 4'h0;
  logic o_hreadyout, o_hresp, pin, busy, o_overflow_gate, o_irq;
  logic [31:0] o_hrdata, rd;
  logic [7:0] c1;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int tq, tw, we, t1, d, p, lo, hi, k;
  int ngate = 0;
  ebtc_row_t rows[6] = '{'{8'h00, 32'hA5, 32'h0, 32'hA5}, '{8'h04, 32'h3A, 32'h3F, 32'h3A},
    '{8'h04, 32'hFFFFFFFF, 32'h3A, 32'h3F}, '{8'h08, 32'h1, 32'h0, 32'h0},
    '{8'h0C, 32'h1, 32'h0, 32'h1}, '{8'h10, 32'hFFFFFFFF, 32'h0, 32'h0}};
  // Starting level alternates per row, so rising and falling counts differ
  // Last row runs the pin through the 1:2 prescaler: four rising edges give two counts
  ebtc_pin_row_t prow[5] = '{'{8'h28, 4'h3, 8'h2}, '{8'h38, 4'h3, 8'h2},
    '{8'h38, 4'h3, 8'h1}, '{8'h28, 4'h3, 8'h1}, '{8'h20, 4'h8, 8'h2}};
  ebtc_timer #(.INSN_DIV(1)) i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2),
    .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_hrdata(o_hrdata), .i_sleep(i_sleep), .i_count_pin(pin),
    .o_overflow_gate(o_overflow_gate), .o_irq(o_irq));
  ebtc_pin_model i_pin (.i_clk(i_clk), .i_go(go), .i_toggles(tog), .o_pin(pin), .o_busy(busy));
  always #4 i_clk = ~i_clk;
  always @(posedge i_clk) cyc <= cyc + 1;
  always @(posedge i_clk) if (o_overflow_gate === 1'b1) ngate <= ngate + 1;
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge i_clk);
    while (o_hreadyout !== 1'b1) begin
      n++;
      if (n > 100) begin
        n_errors++;
        end_sim();
      end
      @(posedge i_clk);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= {24'h0, a};
    i_hwrite <= wr;
    wait_rdy();
    tq = cyc;
    i_htrans <= 2'h0;
    i_hsel <= 1'b0;
    i_hwdata <= wd;
    wait_rdy();
    rd = o_hrdata;
    tw = cyc;
  endtask
  task automatic mark();
    bus(1'b0, 8'h00, 32'h0);
    t1 = tq;
    c1 = rd[7:0];
  endtask
  initial begin
    repeat (6) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, rows[i].a, 32'h0);
      chk("reg before", rows[i].rb, rd);
      bus(1'b1, rows[i].a, rows[i].wd);
      bus(1'b0, rows[i].a, 32'h0);
      chk("reg after", rows[i].ra, rd);
    end
    chk("hresp", 32'h0, {31'h0, o_hresp});
    $display("register table done");
    bus(1'b1, 8'h04, 32'h08);
    bus(1'b1, 8'h00, 32'h40);
    we = tw;
    repeat (4) @(posedge i_clk);
    mark();
    chk("count after write", 32'(8'h40 + 8'(tq - we - 3)), {24'h0, c1});
    repeat (20) @(posedge i_clk);
    bus(1'b0, 8'h00, 32'h0);
    chk("timer step", 32'(8'(tq - t1)), {24'h0, rd[7:0] - c1});
    $display("timer mode done");
    for (int r = 0; r < 8; r++) begin
      bus(1'b1, 8'h04, {29'h0, 3'(r)});
      mark();
      p = 2 << r;
      repeat (4 * p) @(posedge i_clk);
      bus(1'b0, 8'h00, 32'h0);
      d = int'(8'(rd[7:0] - c1));
      lo = (tq - t1) / p;
      hi = (tq - t1 + p - 1) / p;
      chk("prescaled step", 32'((d == hi) ? hi : lo), 32'(d));
    end
    $display("prescaler done");
    bus(1'b1, 8'h0C, 32'h1);
    bus(1'b1, 8'h04, 32'h08);
    bus(1'b1, 8'h08, 32'h1);
    ngate = 0;
    bus(1'b1, 8'h00, 32'hFE);
    repeat (20) @(posedge i_clk);
    chk("irq", 32'h1, {31'h0, o_irq});
    chk("gate pulses", 32'h1, 32'(ngate));
    bus(1'b0, 8'h08, 32'h0);
    chk("flag", 32'h1, rd);
    repeat (2) @(posedge i_clk);
    chk("irq cleared", 32'h0, {31'h0, o_irq});
    bus(1'b1, 8'h0C, 32'h0);
    bus(1'b1, 8'h00, 32'hFE);
    repeat (20) @(posedge i_clk);
    chk("irq masked", 32'h0, {31'h0, o_irq});
    bus(1'b0, 8'h08, 32'h0);
    chk("flag masked", 32'h1, rd);
    $display("overflow done");
    i_sleep <= 1'b1;
    @(posedge i_clk);
    mark();
    repeat (40) @(posedge i_clk);
    bus(1'b0, 8'h00, 32'h0);
    chk("sleep count", {24'h0, c1}, {24'h0, rd[7:0]});
    i_sleep <= 1'b0;
    $display("sleep done");
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, 8'h04, {24'h0, prow[i].ctl});
      mark();
      go <= 1'b1;
      tog <= prow[i].n;
      @(posedge i_clk);
      go <= 1'b0;
      k = 0;
      @(posedge i_clk);
      while (busy === 1'b1 && k < 200) begin
        k++;
        @(posedge i_clk);
      end
      if (busy === 1'b1) begin
        n_errors++;
        end_sim();
      end
      repeat (12) @(posedge i_clk);
      bus(1'b0, 8'h00, 32'h0);
      chk("pin edges", {24'h0, prow[i].e}, {24'h0, rd[7:0] - c1});
    end
    $display("counter mode done");
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk("ready in reset", 32'h0, {31'h0, o_hreadyout});
    i_nrst <= 1'b1;
    @(posedge i_clk);
    bus(1'b0, 8'h04, 32'h0);
    chk("ctrl after reset", 32'h3F, rd);
    bus(1'b0, 8'h00, 32'h0);
    chk("count after reset", 32'h0, rd);
    $display("reset done");
    end_sim();
  end
endmodule
